// ---- rtc_map.svh ----
// Register offsets, field positions, reset values and timing counts
// for the alarm/timer flag block and the time registers.
// Assumes a 40 MHz system clock feeding all timebase dividers.
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH

`define ADDR_CTRL2 8'h01
`define ADDR_SECONDS 8'h02
`define ADDR_MINUTES 8'h03
`define ADDR_HOURS 8'h04
`define ADDR_DAYS 8'h05
`define ADDR_WEEKDAYS 8'h06
`define ADDR_MONTHS 8'h07

`define BIT_PULSE_MODE 4
`define BIT_ALARM_FLAG 3
`define BIT_TIMER_FLAG 2
`define BIT_ALARM_IE 1
`define BIT_TIMER_IE 0
`define BIT_INTEGRITY 7
`define BIT_CENTURY 7

`define RST_SECONDS 7'h00
`define RST_MINUTES 7'h00
`define RST_HOURS 6'h00
`define RST_DAYS 6'h01
`define RST_WEEKDAY 3'h0
`define RST_INTEGRITY 1'b1

`define BCD_59 7'h59
`define BCD_23 6'h23
`define WEEKDAY_LAST 3'h6
`define SEC_PER_MIN_LAST 6'd59

`define CLK_HZ 40000000
`define BASE_HZ 8192
`define ACC_W 26

// Pulse lengths as reciprocal seconds, counts in base ticks
`define PW_DEN_4096_N1 8192
`define PW_DEN_4096 4096
`define PW_DEN_64_N1 128
`define PW_DEN_64 64
`define PW_DEN_SLOW 64

`endif

// ---- rtc_pkg.sv ----
// Types shared by the flag block and the calendar counters.
// Assumes rtc_map.svh supplies the numeric constants.
package rtc_pkg;
	typedef enum logic [1:0] {
		SRC_4096HZ = 2'b00,
		SRC_64HZ = 2'b01,
		SRC_1HZ = 2'b10,
		SRC_1_60HZ = 2'b11
	} tsrc_e;
	typedef logic [7:0] byte_t;
endpackage

// ---- rtc_cal_if.sv ----
// Carrier between the register/flag block and the calendar counters.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface rtc_cal_if;
	logic secTick;
	logic [4:0] wrSel;
	logic [7:0] wrData;
	logic [7:0] month;
	logic [7:0] year;
	logic [6:0] sec;
	logic [6:0] min;
	logic [5:0] hour;
	logic [5:0] day;
	logic [2:0] wday;
	logic dayCarry;
	modport ctrl(output secTick, wrSel, wrData, month, year,
		input sec, min, hour, day, wday, dayCarry);
	modport cal(input secTick, wrSel, wrData, month, year,
		output sec, min, hour, day, wday, dayCarry);
endinterface
`default_nettype wire

// ---- rtc_calendar.sv ----
// BCD seconds, minutes, hours, days and weekday counters.
// Assumes secTick is a one-cycle pulse once per second; month and
// year come from the outer calendar registers as BCD.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_map.svh"
module rtc_calendar (
	input wire logic clk,
	input wire logic rst,
	rtc_cal_if.cal cal
);
	import rtc_pkg::*;

	function automatic logic [7:0] bcdInc(input logic [7:0] v);
		logic [7:0] r;
		r = v + 8'h01;
		if (v[3:0] == 4'h9) begin
			r = {v[7:4] + 4'h1, 4'h0};
		end
		return r;
	endfunction

	logic [6:0] sec_q;
	logic [6:0] min_q;
	logic [5:0] hour_q;
	logic [5:0] day_q;
	logic [2:0] wday_q;
	logic dayCarry_q;

	// Named incremented values, since a select on a call result is not legal
	wire [7:0] secInc = bcdInc({1'b0, sec_q});
	wire [7:0] minInc = bcdInc({1'b0, min_q});
	wire [7:0] hourInc = bcdInc({2'b00, hour_q});
	wire [7:0] dayInc = bcdInc({2'b00, day_q});

	wire minStep = cal.secTick && (sec_q == `BCD_59);
	wire hourStep = minStep && (min_q == `BCD_59);
	wire dayStep = hourStep && (hour_q == `BCD_23);
	// Units digit 0/4/8 with even tens, or 2/6 with odd tens
	wire leapYear = cal.year[4] ? (cal.year[3:0] == 4'h2 || cal.year[3:0] == 4'h6) :
		(cal.year[3:0] == 4'h0 || cal.year[3:0] == 4'h4 || cal.year[3:0] == 4'h8);
	wire shortMonth = cal.month == 8'h04 || cal.month == 8'h06 ||
		cal.month == 8'h09 || cal.month == 8'h11;
	wire [5:0] lastDay = (cal.month == 8'h02) ? (leapYear ? 6'h29 : 6'h28) :
		(shortMonth ? 6'h30 : 6'h31);
	wire monthEnd = dayStep && (day_q == lastDay);

	// Software writes win over a same-cycle count
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sec_q <= `RST_SECONDS;
			min_q <= `RST_MINUTES;
			hour_q <= `RST_HOURS;
			day_q <= `RST_DAYS;
			wday_q <= `RST_WEEKDAY;
			dayCarry_q <= 1'b0;
		end else begin
			dayCarry_q <= monthEnd && !cal.wrSel[3];
			if (cal.wrSel[0]) begin
				sec_q <= cal.wrData[6:0];
			end else if (cal.secTick) begin
				sec_q <= minStep ? 7'h00 : secInc[6:0];
			end
			if (cal.wrSel[1]) begin
				min_q <= cal.wrData[6:0];
			end else if (minStep) begin
				min_q <= hourStep ? 7'h00 : minInc[6:0];
			end
			if (cal.wrSel[2]) begin
				hour_q <= cal.wrData[5:0];
			end else if (hourStep) begin
				hour_q <= dayStep ? 6'h00 : hourInc[5:0];
			end
			if (cal.wrSel[3]) begin
				day_q <= cal.wrData[5:0];
			end else if (dayStep) begin
				day_q <= monthEnd ? `RST_DAYS : dayInc[5:0];
			end
			if (cal.wrSel[4]) begin
				wday_q <= cal.wrData[2:0];
			end else if (dayStep) begin
				wday_q <= (wday_q == `WEEKDAY_LAST) ? 3'h0 : wday_q + 3'h1;
			end
		end
	end

	assign cal.sec = sec_q;
	assign cal.min = min_q;
	assign cal.hour = hour_q;
	assign cal.day = day_q;
	assign cal.wday = wday_q;
	assign cal.dayCarry = dayCarry_q;
endmodule
`default_nettype wire

// ---- rtc_flags_and_time_regs.sv ----
// Alarm/timer flags, interrupt pin control, timer countdown and the
// time registers of the real-time clock, behind a parallel register port.
// Assumes the serial bus engine outside drives the register port and
// that alarm match, timer settings, month and year come from outside.
//
// Function
// - An alarm match sets the alarm flag.
// - Timer countdown end sets the timer flag.
// - Flags hold until software writes them; reads never clear.
// - Control write ANDs each flag with the written bit.
// - Interrupt is OR of alarm flag and timer flag (timer pulse in pulse mode) gated by enables.
// - Level mode: interrupt follows timer flag while timer interrupt enabled.
// - Pulse mode, 4096 Hz source: 1/8192 s for n=1, else 1/4096 s.
// - Pulse mode: 64 Hz gives 1/128 or 1/64 s; slower sources 1/64 s.
// - Pulse mode with alarm flag and enable: interrupt held continuously.
// - With n=1 timer flag and interrupt assert together.
// - Timer stays stopped while the loaded count is zero.
// - Seconds bit 7 flags lost clock integrity.
// - Seconds bits 6..0 hold BCD 00 to 59.
// - Minutes bits 6..0 hold BCD 00 to 59.
// - Hours bits 5..0 hold BCD 00 to 23.
// - Days bits 5..0 hold BCD 01 to 31.
// - February has 29 days when year is divisible by four.
// - Weekday bits 2..0 hold 0 to 6.
// - Weekday simply cycles 0 to 6; software assigns names.
// - Century bit toggles when years roll from 99 to 00.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_map.svh"
module rtc_flags_and_time_regs (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] regAddr,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [7:0] regWrData,
	output logic [7:0] regRdData,
	input wire logic alarmMatch,
	input wire logic voltageLow,
	input wire logic timerRun,
	input wire rtc_pkg::tsrc_e timerSource,
	input wire logic timerLoad,
	input wire logic [7:0] timerLoadValue,
	input wire logic [7:0] monthBcd,
	input wire logic [7:0] yearBcd,
	input wire logic yearWrap,
	output logic centuryBit,
	output logic monthCarry,
	output logic intPinOut,
	output logic intPinOe
);
	import rtc_pkg::*;

	localparam logic [`ACC_W-1:0] ACC_STEP = `ACC_W'(`BASE_HZ);
	localparam logic [`ACC_W-1:0] ACC_WRAP = `ACC_W'(`CLK_HZ);
	localparam logic [7:0] PW_4096_N1 = 8'(`BASE_HZ / `PW_DEN_4096_N1);
	localparam logic [7:0] PW_4096 = 8'(`BASE_HZ / `PW_DEN_4096);
	localparam logic [7:0] PW_64_N1 = 8'(`BASE_HZ / `PW_DEN_64_N1);
	localparam logic [7:0] PW_64 = 8'(`BASE_HZ / `PW_DEN_64);
	localparam logic [7:0] PW_SLOW = 8'(`BASE_HZ / `PW_DEN_SLOW);

	rtc_cal_if calBus();

	rtc_calendar u_calendar (
		.clk(clk),
		.rst(rst),
		.cal(calBus)
	);

	// Timebase: phase accumulator gives an exact 8192 Hz average
	logic [`ACC_W-1:0] acc_q;
	logic baseTick_q;
	logic [12:0] baseCnt_q;
	logic [5:0] minDiv_q;

	wire [`ACC_W:0] accSum = {1'b0, acc_q} + {1'b0, ACC_STEP};
	wire accOver = accSum >= {1'b0, ACC_WRAP};
	wire [`ACC_W-1:0] accNext = accOver ? `ACC_W'(accSum - {1'b0, ACC_WRAP}) :
		accSum[`ACC_W-1:0];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			acc_q <= '0;
			baseTick_q <= 1'b0;
		end else begin
			acc_q <= accNext;
			baseTick_q <= accOver;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			baseCnt_q <= '0;
		end else if (baseTick_q) begin
			baseCnt_q <= baseCnt_q + 13'd1;
		end
	end

	wire tick4096 = baseTick_q && baseCnt_q[0];
	wire tick64 = baseTick_q && (&baseCnt_q[6:0]);
	wire tick1 = baseTick_q && (&baseCnt_q);
	wire tickMin = tick1 && (minDiv_q == `SEC_PER_MIN_LAST);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			minDiv_q <= '0;
		end else if (tick1) begin
			minDiv_q <= tickMin ? 6'd0 : minDiv_q + 6'd1;
		end
	end

	// Register decode
	wire wrCtrl = regWrEn && (regAddr == `ADDR_CTRL2);
	wire wrSec = regWrEn && (regAddr == `ADDR_SECONDS);
	wire wrMin = regWrEn && (regAddr == `ADDR_MINUTES);
	wire wrHour = regWrEn && (regAddr == `ADDR_HOURS);
	wire wrDay = regWrEn && (regAddr == `ADDR_DAYS);
	wire wrWday = regWrEn && (regAddr == `ADDR_WEEKDAYS);
	wire wrMonth = regWrEn && (regAddr == `ADDR_MONTHS);

	// Countdown timer
	logic [7:0] loadN_q;
	logic [7:0] timerCnt_q;
	logic [7:0] pulseCnt_q;

	wire srcTick = (timerSource == SRC_4096HZ) ? tick4096 :
		(timerSource == SRC_64HZ) ? tick64 :
		(timerSource == SRC_1HZ) ? tick1 : tickMin;
	wire timerActive = timerRun && (loadN_q != 8'h00);
	wire timerEnd = timerActive && srcTick && (timerCnt_q <= 8'h01);
	wire nIsOne = loadN_q == 8'h01;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			loadN_q <= '0;
			timerCnt_q <= '0;
		end else if (timerLoad) begin
			loadN_q <= timerLoadValue;
			timerCnt_q <= timerLoadValue;
		end else if (timerActive && srcTick) begin
			timerCnt_q <= timerEnd ? loadN_q : timerCnt_q - 8'h01;
		end
	end

	// Pulse length in base ticks, chosen by source and loaded count
	wire [7:0] pulseLen = (timerSource == SRC_4096HZ) ?
		(nIsOne ? PW_4096_N1 : PW_4096) :
		(timerSource == SRC_64HZ) ? (nIsOne ? PW_64_N1 : PW_64) : PW_SLOW;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pulseCnt_q <= '0;
		end else if (timerEnd) begin
			pulseCnt_q <= pulseLen;
		end else if (baseTick_q && pulseCnt_q != 8'h00) begin
			pulseCnt_q <= pulseCnt_q - 8'h01;
		end
	end

	// Pulse starts on the same edge as the timer flag
	wire pulseNext = timerEnd || (pulseCnt_q > 8'h01) ||
		(pulseCnt_q == 8'h01 && !baseTick_q);

	// Control/status 2 fields
	logic [1:0] flag_q;
	logic [1:0] flag_d;
	logic pulseMode_q;
	logic alarmIe_q;
	logic timerIe_q;
	wire [1:0] flagSet = {alarmMatch, timerEnd};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_flag
			// Set beats a same-cycle clear so no event is lost
			assign flag_d[gi] = flagSet[gi] ||
				(flag_q[gi] && !(wrCtrl && !regWrData[`BIT_TIMER_FLAG + gi]));
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					flag_q[gi] <= 1'b0;
				end else begin
					flag_q[gi] <= flag_d[gi];
				end
			end
		end
	endgenerate

	wire pulseModeD = wrCtrl ? regWrData[`BIT_PULSE_MODE] : pulseMode_q;
	wire alarmIeD = wrCtrl ? regWrData[`BIT_ALARM_IE] : alarmIe_q;
	wire timerIeD = wrCtrl ? regWrData[`BIT_TIMER_IE] : timerIe_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pulseMode_q <= 1'b0;
			alarmIe_q <= 1'b0;
			timerIe_q <= 1'b0;
		end else begin
			pulseMode_q <= pulseModeD;
			alarmIe_q <= alarmIeD;
			timerIe_q <= timerIeD;
		end
	end

	// Interrupt pin: open drain, driven low while active
	wire alarmIrq = flag_d[1] && alarmIeD;
	wire timerIrq = timerIeD && (pulseModeD ? pulseNext : flag_d[0]);
	wire intNext = alarmIrq || timerIrq;
	logic intOe_q;
	logic intOut_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			intOe_q <= 1'b0;
			intOut_q <= 1'b0;
		end else begin
			intOe_q <= intNext;
			intOut_q <= 1'b0;
		end
	end

	// Clock integrity and century
	logic integrityLost_q;
	logic century_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			integrityLost_q <= `RST_INTEGRITY;
		end else if (voltageLow) begin
			integrityLost_q <= 1'b1;
		end else if (wrSec) begin
			integrityLost_q <= regWrData[`BIT_INTEGRITY];
		end
	end

	// Year wrap toggles even if software writes the bit that cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			century_q <= 1'b0;
		end else if (yearWrap) begin
			century_q <= wrMonth ? !regWrData[`BIT_CENTURY] : !century_q;
		end else if (wrMonth) begin
			century_q <= regWrData[`BIT_CENTURY];
		end
	end

	// Calendar link
	assign calBus.secTick = tick1;
	assign calBus.wrSel = {wrWday, wrDay, wrHour, wrMin, wrSec};
	assign calBus.wrData = regWrData;
	assign calBus.month = monthBcd;
	assign calBus.year = yearBcd;

	// Read data, unmapped addresses read zero
	wire [7:0] ctrlRead = {3'b000, pulseMode_q, flag_q[1], flag_q[0],
		alarmIe_q, timerIe_q};
	wire [7:0] rdMux = (regAddr == `ADDR_CTRL2) ? ctrlRead :
		(regAddr == `ADDR_SECONDS) ? {integrityLost_q, calBus.sec} :
		(regAddr == `ADDR_MINUTES) ? {1'b0, calBus.min} :
		(regAddr == `ADDR_HOURS) ? {2'b00, calBus.hour} :
		(regAddr == `ADDR_DAYS) ? {2'b00, calBus.day} :
		(regAddr == `ADDR_WEEKDAYS) ? {5'b00000, calBus.wday} : 8'h00;

	logic [7:0] rdData_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdData_q <= 8'h00;
		end else if (regRdEn) begin
			rdData_q <= rdMux;
		end
	end

	assign regRdData = rdData_q;
	assign centuryBit = century_q;
	assign monthCarry = calBus.dayCarry;
	assign intPinOut = intOut_q;
	assign intPinOe = intOe_q;
endmodule
`default_nettype wire

// ---- rtc_host.sv ----
// Host model driving the byte register port behind the serial engine.
// Assumes one clock; the bench calls wr and rd by hierarchy.
`timescale 1ns/1ps
`default_nettype none
module rtc_host (
	input wire logic clk,
	input wire logic [7:0] regRdData,
	output logic [7:0] regAddr,
	output logic regWrEn,
	output logic regRdEn,
	output logic [7:0] regWrData
);
	initial begin
		regAddr = 8'h00;
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		regWrData = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		#1;
		regAddr = a;
		regWrData = v;
		regWrEn = 1'b1;
		@(posedge clk);
		#1;
		regWrEn = 1'b0;
		// Released data must not look valid
		regWrData = ~v;
	endtask
	// Flags are read back to find the interrupt source
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		#1;
		regAddr = a;
		regRdEn = 1'b1;
		@(posedge clk);
		#1;
		regRdEn = 1'b0;
		v = regRdData;
	endtask
endmodule
`default_nettype wire

// ---- rtc_flags_and_time_regs_properties.sv ----
// Port-level checks for the flag, interrupt and time register block.
// Assumes one clock; control shadow tracks host writes to 0x01.
`timescale 1ns/1ps
`default_nettype none
module rtc_flags_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] regAddr,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [7:0] regWrData,
	input wire logic [7:0] regRdData,
	input wire logic alarmMatch,
	input wire logic voltageLow,
	input wire logic timerRun,
	input wire rtc_pkg::tsrc_e timerSource,
	input wire logic timerLoad,
	input wire logic [7:0] timerLoadValue,
	input wire logic yearWrap,
	input wire logic centuryBit,
	input wire logic intPinOut,
	input wire logic intPinOe
);
	import rtc_pkg::*;
	logic [4:0] ctlQ;
	logic [7:0] nQ;
	logic ranQ;
	wire logic wrCtl;
	assign wrCtl = regWrEn && regAddr == 8'h01;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctlQ <= 5'h00;
			nQ <= 8'h00;
			ranQ <= 1'b0;
		end else begin
			if (wrCtl) ctlQ <= regWrData[4:0];
			if (timerLoad) nQ <= timerLoadValue;
			if (timerLoad && timerLoadValue != 8'h00) ranQ <= 1'b1;
		end
	end
	// Pulse length is too long for a delay range, so count high cycles
	localparam int PW_MAX = 4884;
	logic [15:0] pwCntQ;
	wire logic pwWatch;
	assign pwWatch = ctlQ[4] && !ctlQ[1] && nQ == 8'h01 && timerSource == SRC_4096HZ &&
		intPinOe;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pwCntQ <= 16'h0000;
		end else if (pwWatch) begin
			pwCntQ <= pwCntQ + 16'h0001;
		end else begin
			pwCntQ <= 16'h0000;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_pin_drive_low: assert property (intPinOut == 1'b0) else $error("pin value not low");
	a_int_needs_enable: assert property (!ctlQ[1] && !ctlQ[0] |-> !intPinOe)
		else $error("interrupt without enable");
	a_alarm_raises_int: assert property (alarmMatch && ctlQ[1] && !wrCtl |=> intPinOe)
		else $error("alarm did not raise interrupt");
	a_alarm_int_holds: assert property (intPinOe && ctlQ[1] && !ctlQ[0] && !wrCtl |=> intPinOe)
		else $error("alarm interrupt dropped");
	a_level_int_holds: assert property (intPinOe && !ctlQ[4] && !wrCtl |=> intPinOe)
		else $error("level interrupt dropped");
	a_pulse_width_short: assert property (pwCntQ <= PW_MAX)
		else $error("timer pulse too long");
	a_timer_stays_idle: assert property (!ranQ && !ctlQ[1] |-> !intPinOe)
		else $error("timer ran with zero count");
	a_ctrl_top_zero: assert property (regRdEn && regAddr == 8'h01 |=> regRdData[7:5] == 3'b000)
		else $error("control top bits not zero");
	a_unmapped_reads_zero: assert property (regRdEn && (regAddr == 8'h00 || regAddr > 8'h06)
		|=> regRdData == 8'h00) else $error("unmapped read not zero");
	a_read_data_stands: assert property (!regRdEn |=> $stable(regRdData))
		else $error("read data changed without read");
	a_vlow_sets_integrity: assert property (voltageLow ##[1:4] (regRdEn && regAddr == 8'h02
		&& !regWrEn) |=> regRdData[7]) else $error("integrity bit not set");
	a_century_toggles: assert property (yearWrap |=> centuryBit != $past(centuryBit))
		else $error("century bit not toggled");
	c_alarm_int: cover property (alarmMatch && ctlQ[1]);
	c_pulse_end: cover property ($fell(intPinOe) && ctlQ[4]);
	c_century: cover property (yearWrap);
endmodule
bind rtc_flags_and_time_regs rtc_flags_checker props (
	.clk(clk), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn), .regRdEn(regRdEn),
	.regWrData(regWrData), .regRdData(regRdData), .alarmMatch(alarmMatch),
	.voltageLow(voltageLow), .timerRun(timerRun), .timerSource(timerSource),
	.timerLoad(timerLoad), .timerLoadValue(timerLoadValue), .yearWrap(yearWrap),
	.centuryBit(centuryBit), .intPinOut(intPinOut), .intPinOe(intPinOe)
);
`default_nettype wire

// ---- rtc_flags_and_time_regs_bench.sv ----
// Self-checking bench for the flag, interrupt and time register block.
// Assumes rtc_host drives the register port; calendar rollover is too slow to reach.
`timescale 1ns/1ps
`default_nettype none
module rtc_flags_and_time_regs_bench;
	import rtc_pkg::*;
	logic clk = 1'b0, rst = 1'b1, alarmMatch = 1'b0, voltageLow = 1'b0, timerRun = 1'b0;
	logic timerLoad = 1'b0, yearWrap = 1'b0, regWrEn, regRdEn, centuryBit, monthCarry;
	logic intPinOut, intPinOe;
	logic [7:0] regAddr, regWrData, regRdData, d, a;
	logic [7:0] timerLoadValue = 8'h00;
	tsrc_e timerSource = SRC_4096HZ;
	logic [7:0] tv [5] = '{8'h59, 8'h59, 8'h23, 8'h31, 8'h06};
	int mismatches = 0, tests_run = 0;
	always #12.5 clk = ~clk;
	rtc_flags_and_time_regs uut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn),
		.regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData),
		.alarmMatch(alarmMatch), .voltageLow(voltageLow), .timerRun(timerRun),
		.timerSource(timerSource), .timerLoad(timerLoad), .timerLoadValue(timerLoadValue),
		.monthBcd(8'h02), .yearBcd(8'h24), .yearWrap(yearWrap), .centuryBit(centuryBit),
		.monthCarry(monthCarry), .intPinOut(intPinOut), .intPinOe(intPinOe));
	rtc_host host (.clk(clk), .regRdData(regRdData), .regAddr(regAddr), .regWrEn(regWrEn),
		.regRdEn(regRdEn), .regWrData(regWrData));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask
	task automatic rdchk(input logic [7:0] adr, input logic [7:0] exp);
		host.rd(adr, d);
		chk(d, exp, "register read");
	endtask
	task automatic pinchk(input logic exp);
		chk({7'h00, intPinOe}, {7'h00, exp}, "interrupt pin");
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		@(posedge clk);
		#1;
		s = 1'b0;
	endtask
	// Bounded wait; a miss shows up in the pin compare
	task automatic waitOe(input logic lvl, input int lim);
		int i;
		for (i = 0; i < lim && intPinOe !== lvl; i++) begin
			@(posedge clk);
			#1;
		end
		pinchk(lvl);
	endtask
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		#(80000 * 25);
		mismatches++;
		finish_test();
	end
	initial begin
		repeat (8) @(posedge clk);
		#1;
		rst = 1'b0;
		rdchk(8'h01, 8'h00);
		rdchk(8'h02, 8'h80);
		rdchk(8'h05, 8'h01);
		rdchk(8'h10, 8'h00);
		host.wr(8'h01, 8'hff);
		rdchk(8'h01, 8'h13);
		for (a = 8'h02; a < 8'h07; a++) begin
			host.wr(a, tv[a - 8'h02]);
			rdchk(a, tv[a - 8'h02]);
		end
		pulse(voltageLow);
		rdchk(8'h02, 8'hd9);
		host.wr(8'h01, 8'h02);
		pulse(alarmMatch);
		pinchk(1'b1);
		rdchk(8'h01, 8'h0a);
		rdchk(8'h01, 8'h0a);
		pulse(timerLoad);
		timerRun = 1'b1;
		host.wr(8'h01, 8'h19);
		repeat (12000) @(posedge clk);
		#1;
		pinchk(1'b0);
		rdchk(8'h01, 8'h19);
		timerLoadValue = 8'h01;
		pulse(timerLoad);
		waitOe(1'b1, 12000);
		rdchk(8'h01, 8'h1d);
		waitOe(1'b0, 6000);
		rdchk(8'h01, 8'h1d);
		host.wr(8'h01, 8'h17);
		rdchk(8'h01, 8'h17);
		timerRun = 1'b0;
		host.wr(8'h01, 8'h05);
		pinchk(1'b1);
		host.wr(8'h01, 8'h04);
		pinchk(1'b0);
		host.wr(8'h01, 8'h16);
		pulse(alarmMatch);
		repeat (200) @(posedge clk);
		#1;
		pinchk(1'b1);
		pulse(yearWrap);
		chk({7'h00, centuryBit}, 8'h01, "century bit");
		rdchk(8'h07, 8'h00);
		finish_test();
	end
endmodule
`default_nettype wire
